// File: lsd_sink_driver.sv
// Notes on behaviour
// - Latch and blank act by level, not edge.
// - Strobe low keeps the latch unchanged.
// - Strobe high makes the latch copy chain.
// - Blank low: each sink follows its latch bit.
// - Blank high forces every sink off.
// - Sixteen-stage chain, last stage drives serial out.
// - After entry key, detection mode; fifth edge switches.
// - Blank low in detection drives and checks sinks.
// - Blank low one microsecond; rise loads results.
// - Sixteen clocks load ones; two plus one follow.
// - Results leave output fifteen first, downward.
// - Results share data format; a new check needs only another blank-low pulse.
// - Sensed current at most half flags a fault.
// - Output voltage at least high threshold flags fault.
// - Blank is active-high off; strobe doubles as key.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_map.svh"

module lsd_sink_driver (
   // Clock and reset.
   input  wire logic                   clock_in,
   input  wire logic                   reset_n_in,
   // Controller pins.
   input  wire lsd_pkg::lsd_pins_t     pins_in,
   // Comparator flags from the sink sense circuits.
   input  wire lsd_pkg::lsd_sense_t    sense_in,
   // Sinks, serial output and detection-mode flag.
   output var  logic [`LSD_WIDTH-1:0]  sink_outputs_out,
   output var  logic                   serial_out_out,
   output var  logic                   error_detect_mode_out
);

   localparam logic [`LSD_STEPS-1:0] ENTRY_BLANK   = `LSD_ENTRY_BLANK;
   localparam logic [`LSD_STEPS-1:0] ENTRY_STROBE  = `LSD_ENTRY_STROBE;
   localparam logic [`LSD_STEPS-1:0] RESUME_BLANK  = `LSD_RESUME_BLANK;
   localparam logic [`LSD_STEPS-1:0] RESUME_STROBE = `LSD_RESUME_STROBE;
   localparam logic [`LSD_COUNT_W-1:0] DETECT_CYCLES = `LSD_COUNT_W'(`LSD_DETECT_CYCLES);

   // Every pin and comparator flag passes two flip-flops before use.
   lsd_pkg::lsd_pins_t  pins_meta_reg;
   lsd_pkg::lsd_pins_t  pins_reg;
   lsd_pkg::lsd_sense_t sense_meta_reg;
   lsd_pkg::lsd_sense_t sense_reg;
   logic                clock_prev_reg;
   logic                blank_prev_reg;

   logic [`LSD_WIDTH-1:0]   chain_reg;
   logic [`LSD_WIDTH-1:0]   chain_next;
   logic [`LSD_WIDTH-1:0]   latch_reg;
   logic [`LSD_WIDTH-1:0]   latch_next;
   logic [`LSD_WIDTH-1:0]   sink_reg;
   logic [`LSD_WIDTH-1:0]   sink_next;
   logic [`LSD_WIDTH-1:0]   result;
   logic                    serial_reg;
   logic                    serial_next;
   lsd_pkg::lsd_mode_t      mode_reg;
   lsd_pkg::lsd_mode_t      mode_next;
   logic [2:0]              step_reg;
   logic [2:0]              step_next;
   logic [`LSD_COUNT_W-1:0] low_count_reg;
   logic [`LSD_COUNT_W-1:0] low_count_next;
   logic                    shift_rise;
   logic                    blank_rise;
   logic                    load_results;
   logic                    key_match;
   logic                    key_first;
   logic [`LSD_STEPS-1:0]   want_blank;
   logic [`LSD_STEPS-1:0]   want_strobe;

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         pins_meta_reg  <= '0;
         pins_reg       <= '0;
         sense_meta_reg <= '0;
         sense_reg      <= '0;
      end else begin
         pins_meta_reg  <= pins_in;
         pins_reg       <= pins_meta_reg;
         sense_meta_reg <= sense_in;
         sense_reg      <= sense_meta_reg;
      end
   end

   always_comb begin
      shift_rise = pins_reg.shift_clock && !clock_prev_reg;
      blank_rise = pins_reg.output_blank && !blank_prev_reg;
      // A short low pulse would catch the sinks before they settle, so it loads nothing.
      load_results = (mode_reg == lsd_pkg::LSD_DETECT) && blank_rise
                     && (low_count_reg >= DETECT_CYCLES);
      result = ~(sense_reg.current_low | sense_reg.voltage_high);
      low_count_next = low_count_reg;
      if (pins_reg.output_blank) begin
         low_count_next = '0;
      end else if (low_count_reg < DETECT_CYCLES) begin
         low_count_next = low_count_reg + 1'h1;
      end
      chain_next = chain_reg;
      if (load_results) begin
         chain_next = result;
      end else if (shift_rise) begin
         chain_next = {chain_reg[`LSD_WIDTH-2:0], pins_reg.serial_in};
      end
      serial_next = chain_next[`LSD_WIDTH-1];
      // Strobe and blank act on their levels at every system clock, not shift edges.
      latch_next = pins_reg.latch_strobe ? chain_reg : latch_reg;
      sink_next = pins_reg.output_blank ? '0 : latch_next;
   end

   always_comb begin
      if (mode_reg == lsd_pkg::LSD_NORMAL) begin
         want_blank  = ENTRY_BLANK;
         want_strobe = ENTRY_STROBE;
      end else begin
         want_blank  = RESUME_BLANK;
         want_strobe = RESUME_STROBE;
      end
      key_match = (pins_reg.output_blank == want_blank[step_reg])
                  && (pins_reg.latch_strobe == want_strobe[step_reg]);
      key_first = (pins_reg.output_blank == want_blank[0])
                  && (pins_reg.latch_strobe == want_strobe[0]);
      step_next = step_reg;
      mode_next = mode_reg;
      if (shift_rise) begin
         if (!key_match) begin
            step_next = key_first ? 3'h1 : 3'h0;
         end else if (step_reg == `LSD_LAST_STEP) begin
            step_next = 3'h0;
            case (mode_reg)
               lsd_pkg::LSD_NORMAL: mode_next = lsd_pkg::LSD_DETECT;
               lsd_pkg::LSD_DETECT: mode_next = lsd_pkg::LSD_NORMAL;
               default:             mode_next = lsd_pkg::LSD_NORMAL;
            endcase
         end else begin
            step_next = step_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         clock_prev_reg <= 1'h0;
         blank_prev_reg <= 1'h0;
         chain_reg      <= `LSD_CHAIN_RESET;
         latch_reg      <= `LSD_LATCH_RESET;
         sink_reg       <= '0;
         serial_reg     <= 1'h0;
         mode_reg       <= lsd_pkg::LSD_NORMAL;
         step_reg       <= 3'h0;
         low_count_reg  <= '0;
      end else begin
         clock_prev_reg <= pins_reg.shift_clock;
         blank_prev_reg <= pins_reg.output_blank;
         chain_reg      <= chain_next;
         latch_reg      <= latch_next;
         sink_reg       <= sink_next;
         serial_reg     <= serial_next;
         mode_reg       <= mode_next;
         step_reg       <= step_next;
         low_count_reg  <= low_count_next;
      end
   end

   assign sink_outputs_out      = sink_reg;
   assign serial_out_out        = serial_reg;
   assign error_detect_mode_out = (mode_reg == lsd_pkg::LSD_DETECT);

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   property p_blank_off;
      pins_reg.output_blank |=> sink_outputs_out == '0;
   endproperty
   a_blank_off: assert property (p_blank_off) else $error("sink on while blanked");

   property p_latch_hold;
      !pins_reg.latch_strobe |=> latch_reg == $past(latch_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

   // The latch copies the chain as it stood one clock earlier, before any shift made in that clock.
   property p_latch_copy;
      pins_reg.latch_strobe |=> latch_reg == $past(chain_reg);
   endproperty
   a_latch_copy: assert property (p_latch_copy) else $error("latch not transparent");

   property p_sink_follow;
      !pins_reg.output_blank && !pins_reg.latch_strobe |=> sink_outputs_out == latch_reg;
   endproperty
   a_sink_follow: assert property (p_sink_follow) else $error("sink not following");

   property p_shift;
      shift_rise && !load_results
         |=> chain_reg == {$past(chain_reg[`LSD_WIDTH-2:0]), $past(pins_reg.serial_in)};
   endproperty
   a_shift: assert property (p_shift) else $error("chain did not shift");

   property p_serial;
      $rose(chain_reg[`LSD_WIDTH-1]) |-> serial_out_out;
   endproperty
   a_serial: assert property (p_serial) else $error("serial out lags chain");

   property p_mode_toggle;
      shift_rise && key_match && step_reg == `LSD_LAST_STEP
         |=> error_detect_mode_out != $past(error_detect_mode_out);
   endproperty
   a_mode_toggle: assert property (p_mode_toggle) else $error("key not honoured");

   property p_key_restart;
      shift_rise && !key_match && !key_first |=> step_reg == 3'h0 && $stable(mode_reg);
   endproperty
   a_key_restart: assert property (p_key_restart) else $error("key tracking kept");

   property p_load;
      load_results |=> chain_reg == ~($past(sense_reg.current_low) | $past(sense_reg.voltage_high));
   endproperty
   a_load: assert property (p_load) else $error("results not loaded");

   property p_no_early_load;
      blank_rise && low_count_reg < DETECT_CYCLES && !shift_rise |=> $stable(chain_reg);
   endproperty
   a_no_early_load: assert property (p_no_early_load) else $error("early result load");

endmodule

`default_nettype wire

// File: lsd_map.svh
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

// Number of shift stages, latch bits and sink outputs.
`define LSD_WIDTH          16
// Mode key patterns, bit n is the level expected at the (n+1)th shift-clock rise.
`define LSD_STEPS          5
`define LSD_ENTRY_BLANK    5'h1d
`define LSD_ENTRY_STROBE   5'h08
`define LSD_RESUME_BLANK   5'h1d
`define LSD_RESUME_STROBE  5'h00
`define LSD_LAST_STEP      3'h4
// Reset values.
`define LSD_CHAIN_RESET    16'h0000
`define LSD_LATCH_RESET    16'h0000
// Least time the blank input is held low during detection.
`define LSD_CLOCK_NS       100
`define LSD_DETECT_MIN_NS  1000
`define LSD_DETECT_CYCLES  ((`LSD_DETECT_MIN_NS + `LSD_CLOCK_NS - 1) / `LSD_CLOCK_NS)
`define LSD_COUNT_W        4

`endif

// File: lsd_pkg.sv
`default_nettype none
`include "lsd_map.svh"

package lsd_pkg;

   typedef struct packed {
      logic shift_clock;
      logic serial_in;
      logic latch_strobe;
      logic output_blank;
   } lsd_pins_t;

   typedef struct packed {
      logic [`LSD_WIDTH-1:0] current_low;
      logic [`LSD_WIDTH-1:0] voltage_high;
   } lsd_sense_t;

   typedef enum logic {
      LSD_NORMAL,
      LSD_DETECT
   } lsd_mode_t;

endpackage

`default_nettype wire

// File: lsd_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

module lsd_mcu_model (
   // Clock.
   input  wire logic               clock_in,
   // Controller pins towards the driver.
   output var  lsd_pkg::lsd_pins_t pins_out
);

   initial begin
      pins_out = '0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask

   task automatic levels(input logic strobe, input logic blank, input int n);
      pins_out.latch_strobe = strobe;
      pins_out.output_blank = blank;
      wait_cyc(n);
   endtask

   // Levels settle four clocks before the rise and stay four after it, so the
   // two-flop sampling path of the driver never catches them in transit.
   task automatic pulse(input logic sin, input logic strobe, input logic blank);
      pins_out.serial_in = sin;
      levels(strobe, blank, 4);
      pins_out.shift_clock = 1'h1;
      wait_cyc(4);
      pins_out.shift_clock = 1'h0;
   endtask

   // Both keys walk blank through high, low, high, high, high; only the strobe differs.
   task automatic key(input logic [4:0] strobe);
      for (int i = 0; i < 5; i++) begin
         pulse(1'h0, strobe[i], (i != 1));
      end
      levels(1'h0, 1'h1, 4);
   endtask

endmodule

`default_nettype wire

// File: led_sink_shift_latch_with_fault_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none

module led_sink_shift_latch_with_fault_detect_tb;

   logic                clock_in;
   logic                reset_n_in;
   lsd_pkg::lsd_pins_t  pins;
   lsd_pkg::lsd_sense_t sense;
   logic [15:0]         sinks;
   logic                sout;
   logic                mode;
   int                  error_cnt;
   int                  checked;

   always #50 clock_in = ~clock_in;

   lsd_sink_driver dut_u (
      .clock_in              (clock_in),
      .reset_n_in            (reset_n_in),
      .pins_in               (pins),
      .sense_in              (sense),
      .sink_outputs_out      (sinks),
      .serial_out_out        (sout),
      .error_detect_mode_out (mode)
   );

   lsd_mcu_model mcu_u (
      .clock_in (clock_in),
      .pins_out (pins)
   );

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic t_shift_latch;
      logic [15:0] pat;
      pat = 16'ha5c3;
      for (int i = 15; i >= 0; i--) begin
         mcu_u.pulse(pat[i], 1'h0, 1'h0);
      end
      cmp(sinks, 16'h0000, "latch held");
      cmp_bit(sout, pat[15], "serial out");
      mcu_u.levels(1'h1, 1'h0, 8);
      cmp(sinks, pat, "latch open");
      mcu_u.levels(1'h0, 1'h1, 8);
      cmp(sinks, 16'h0000, "blanked");
      mcu_u.levels(1'h0, 1'h0, 8);
      cmp(sinks, pat, "unblanked");
      mcu_u.pulse(1'h0, 1'h0, 1'h0);
      cmp_bit(sout, pat[14], "next bit");
      cmp(sinks, pat, "shift behind closed latch");
   endtask

   // A wrong strobe step or the resume key alone must not leave normal mode.
   task automatic t_bad_key;
      mcu_u.key(5'h04);
      cmp_bit(mode, 1'h0, "misplaced strobe");
      mcu_u.key(5'h00);
      cmp_bit(mode, 1'h0, "resume in normal");
   endtask

   task automatic t_detect;
      logic [15:0] res;
      sense.current_low = 16'h0081;
      sense.voltage_high = 16'h4002;
      res = 16'hbf7c;
      mcu_u.key(5'h08);
      cmp_bit(mode, 1'h1, "entry");
      for (int i = 0; i < 16; i++) begin
         mcu_u.pulse(1'h1, 1'h0, 1'h1);
      end
      mcu_u.levels(1'h1, 1'h1, 6);
      mcu_u.levels(1'h0, 1'h1, 2);
      mcu_u.levels(1'h0, 1'h0, 12);
      cmp(sinks, 16'hffff, "sinks driven");
      // Outputs 0, 1, 7 and 14 carry a fault, so their result bits read 0.
      mcu_u.levels(1'h0, 1'h1, 6);
      for (int i = 15; i >= 0; i--) begin
         cmp_bit(sout, res[i], "result bit");
         if (i > 0) begin
            mcu_u.pulse(1'h0, 1'h0, 1'h1);
         end
      end
      mcu_u.key(5'h00);
      cmp_bit(mode, 1'h0, "resume");
   endtask

   initial begin
      clock_in = 1'h0;
      reset_n_in = 1'h0;
      sense = '0;
      error_cnt = 0;
      checked = 0;
      repeat (5) @(posedge clock_in);
      #1;
      reset_n_in = 1'h1;
      mcu_u.wait_cyc(4);
      cmp(sinks, 16'h0000, "reset sinks");
      t_shift_latch();
      t_bad_key();
      t_detect();
      end_of_test();
   end

   // The whole run needs well under a millisecond; twice that means a hang.
   initial begin
      #2000000;
      error_cnt++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test();
   end

endmodule

`default_nettype wire
